// [rtl/dcc_core_control.sv]
// Core control register bank with debounce, host write modes, mutes and safeload start.
`timescale 1ns/100ps
module dcc_core_control #(
   parameter int N_MP       = 12,
   parameter int N_AUX      = 4,
   parameter int AUX_W      = 12,
   parameter int N_IF       = 8,
   parameter int IF_W       = 32,
   parameter int DEB_CYC_00 = dcc_pkg::DEB_CYC_00,
   parameter int DEB_CYC_01 = dcc_pkg::DEB_CYC_01,
   parameter int DEB_CYC_10 = dcc_pkg::DEB_CYC_10,
   parameter int DEB_CYC_11 = dcc_pkg::DEB_CYC_11
) (
   input  wire logic                                i_clk,
   input  wire logic                                i_rst_n,
   input  wire logic                                i_cp_wr,
   input  wire logic                                i_cp_rd,
   input  wire logic [dcc_pkg::CP_ADDR_W-1:0]       i_cp_addr,
   input  wire logic [dcc_pkg::CP_DATA_W-1:0]       i_cp_wdata,
   output logic      [dcc_pkg::CP_DATA_W-1:0]       o_cp_rdata,
   output logic                                     o_cp_rvalid,
   input  wire logic [N_MP-1:0]                     i_mp_pin,
   input  wire logic [N_MP-1:0]                     i_gpio_in_en,
   output logic      [N_MP-1:0]                     o_gpio_level,
   input  wire logic [N_AUX-1:0][AUX_W-1:0]         i_aux_adc_data,
   output logic      [N_AUX-1:0][AUX_W-1:0]         o_aux_adc_data,
   input  wire logic                                i_dsp_if_we,
   input  wire logic [2:0]                          i_dsp_if_idx,
   input  wire logic [IF_W-1:0]                     i_dsp_if_data,
   output logic      [N_IF-1:0][IF_W-1:0]           o_if_data,
   output logic                                     o_pram_we,
   output logic      [dcc_pkg::SL_ADDR_W-1:0]       o_pram_addr,
   output logic      [dcc_pkg::SL_DATA_W-1:0]       o_pram_data,
   output logic                                     o_adc_mute,
   output logic                                     o_dac_mute,
   output logic                                     o_core_clear,
   output logic      [10:0]                         o_instr_per_sample,
   output logic                                     o_gp_host_write_mode
);

   // ---------------------------------------------------------------
   // Decoding helpers.
   // ---------------------------------------------------------------
   function automatic logic in_range(input logic [11:0] a, input logic [11:0] lo, input logic [11:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic [2:0] offset_of(input logic [11:0] a, input logic [11:0] lo);
      logic [11:0] d;
      d         = a - lo;
      offset_of = d[2:0];
   endfunction

   // ---------------------------------------------------------------
   // Control register and its fields.
   // ---------------------------------------------------------------
   logic [15:0] ctrl_reg, ctrl_next;
   logic        ist_reg,  ist_next;
   logic        again_reg, again_next;
   logic        host_wr_ctrl;
   logic        aux_host_write_mode;
   logic        interface_host_write_mode;
   logic [1:0]  gpio_debounce_select;
   logic [1:0]  sample_rate_select;

   dcc_safeload_if sl ();

   assign host_wr_ctrl              = i_cp_wr && (i_cp_addr == dcc_pkg::LOC_CORE_CTRL);
   assign aux_host_write_mode       = ctrl_reg[dcc_pkg::BIT_AUX_HW];
   assign interface_host_write_mode = ctrl_reg[dcc_pkg::BIT_IF_HW];
   assign gpio_debounce_select      = ctrl_reg[dcc_pkg::BIT_DEB_LO +: 2];
   assign sample_rate_select        = ctrl_reg[dcc_pkg::BIT_RATE_LO +: 2];

   // Reserved bits are never stored, so whatever the host writes there reads back zero.
   // The initiate bit lives apart: a host write of 1 in the done cycle wins over the clear.
   // A write of 1 earlier in a scan is remembered, so a second transfer follows the first.
   always_comb begin
      ctrl_next  = ctrl_reg;
      ist_next   = ist_reg;
      again_next = again_reg;
      if (sl.done) begin
         ist_next   = again_reg;
         again_next = 1'b0;
      end
      if (host_wr_ctrl) begin
         ctrl_next = i_cp_wdata[15:0] & dcc_pkg::CTRL_WMASK;
         if (i_cp_wdata[dcc_pkg::BIT_SL_INIT]) begin
            ist_next = 1'b1;
            if (sl.busy && !sl.done) begin
               again_next = 1'b1;
            end
         end
      end
   end

   // Control register stage.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_reg  <= dcc_pkg::CTRL_RESET;
         ist_reg   <= 1'b0;
         again_reg <= 1'b0;
      end else begin
         ctrl_reg  <= ctrl_next;
         ist_reg   <= ist_next;
         again_reg <= again_next;
      end
   end

   // The engine restarts on its own if the host raised the bit again during a transfer.
   assign sl.start      = ist_reg;
   assign sl.wr         = i_cp_wr && (in_range(i_cp_addr, dcc_pkg::LOC_SLD_FIRST, dcc_pkg::LOC_SLD_LAST)
                                   || in_range(i_cp_addr, dcc_pkg::LOC_SLA_FIRST, dcc_pkg::LOC_SLA_LAST));
   assign sl.wr_is_addr = in_range(i_cp_addr, dcc_pkg::LOC_SLA_FIRST, dcc_pkg::LOC_SLA_LAST);
   assign sl.wr_idx     = sl.wr_is_addr ? offset_of(i_cp_addr, dcc_pkg::LOC_SLA_FIRST)
                                        : offset_of(i_cp_addr, dcc_pkg::LOC_SLD_FIRST);
   assign sl.wr_data    = i_cp_wdata;

   dcc_safeload u_safeload (
      .i_clk       (i_clk),
      .i_rst_n     (i_rst_n),
      .sl          (sl),
      .o_pram_we   (o_pram_we),
      .o_pram_addr (o_pram_addr),
      .o_pram_data (o_pram_data)
   );

   // ---------------------------------------------------------------
   // Auxiliary ADC data and interface registers.
   // ---------------------------------------------------------------
   logic [N_AUX-1:0][AUX_W-1:0] aux_reg, aux_next;
   logic [N_IF-1:0][IF_W-1:0]   if_reg,  if_next;
   logic                        host_wr_aux;
   logic                        host_wr_if;

   assign host_wr_aux = i_cp_wr && in_range(i_cp_addr, dcc_pkg::LOC_AUX_FIRST, dcc_pkg::LOC_AUX_LAST);
   assign host_wr_if  = i_cp_wr && in_range(i_cp_addr, dcc_pkg::LOC_IF_FIRST, dcc_pkg::LOC_IF_LAST);

   // Outside host mode the aux registers track the converters and host writes are dropped;
   // the interface registers likewise belong either to the program or to the host, never both.
   always_comb begin
      aux_next = aux_reg;
      if_next  = if_reg;
      if (aux_host_write_mode) begin
         if (host_wr_aux) begin
            aux_next[offset_of(i_cp_addr, dcc_pkg::LOC_AUX_FIRST)] = i_cp_wdata[AUX_W-1:0];
         end
      end else begin
         aux_next = i_aux_adc_data;
      end
      if (interface_host_write_mode) begin
         if (host_wr_if) begin
            if_next[offset_of(i_cp_addr, dcc_pkg::LOC_IF_FIRST)] = i_cp_wdata[IF_W-1:0];
         end
      end else if (i_dsp_if_we) begin
         if_next[i_dsp_if_idx] = i_dsp_if_data;
      end
   end

   // Data register stage.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aux_reg <= '0;
         if_reg  <= '0;
      end else begin
         aux_reg <= aux_next;
         if_reg  <= if_next;
      end
   end

   assign o_aux_adc_data = aux_reg;
   assign o_if_data      = if_reg;

   // ---------------------------------------------------------------
   // Read port.
   // ---------------------------------------------------------------
   logic [dcc_pkg::CP_DATA_W-1:0] rdata_reg, rdata_next;
   logic                          rvalid_reg, rvalid_next;

   // Safeload registers are write-only and read zero, as do unmapped locations.
   always_comb begin
      rdata_next  = rdata_reg;
      rvalid_next = i_cp_rd;
      if (i_cp_rd) begin
         rdata_next = '0;
         if (i_cp_addr == dcc_pkg::LOC_CORE_CTRL) begin
            rdata_next = dcc_pkg::CP_DATA_W'(ctrl_reg);
            rdata_next[dcc_pkg::BIT_SL_INIT] = ist_reg;
         end else if (in_range(i_cp_addr, dcc_pkg::LOC_AUX_FIRST, dcc_pkg::LOC_AUX_LAST)) begin
            rdata_next = dcc_pkg::CP_DATA_W'(aux_reg[offset_of(i_cp_addr, dcc_pkg::LOC_AUX_FIRST)]);
         end else if (in_range(i_cp_addr, dcc_pkg::LOC_IF_FIRST, dcc_pkg::LOC_IF_LAST)) begin
            rdata_next = dcc_pkg::CP_DATA_W'(if_reg[offset_of(i_cp_addr, dcc_pkg::LOC_IF_FIRST)]);
         end
      end
   end

   // Read register stage.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_reg  <= '0;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg  <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   assign o_cp_rdata  = rdata_reg;
   assign o_cp_rvalid = rvalid_reg;

   // ---------------------------------------------------------------
   // Core-facing controls.
   // ---------------------------------------------------------------
   logic [10:0] ips;

   // The reserved rate code falls back to the slowest rate so the core never overruns.
   always_comb begin
      case (sample_rate_select)
         2'h0:    ips = dcc_pkg::IPS_1X;
         2'h1:    ips = dcc_pkg::IPS_2X;
         2'h2:    ips = dcc_pkg::IPS_4X;
         default: ips = dcc_pkg::IPS_1X;
      endcase
   end

   assign o_instr_per_sample   = ips;
   assign o_adc_mute           = ~ctrl_reg[dcc_pkg::BIT_ADC_UNM];
   assign o_dac_mute           = ~ctrl_reg[dcc_pkg::BIT_DAC_UNM];
   assign o_core_clear         = ~ctrl_reg[dcc_pkg::BIT_CORE_RUN];
   assign o_gp_host_write_mode = ctrl_reg[dcc_pkg::BIT_GP_HW];

   // ---------------------------------------------------------------
   // GPIO debounce.
   // ---------------------------------------------------------------
   logic [dcc_pkg::DEB_CNT_W-1:0] deb_limit;

   // Cycle count of the selected debounce time, shared by every pin's counter.
   always_comb begin
      case (gpio_debounce_select)
         2'h0:    deb_limit = dcc_pkg::DEB_CNT_W'(DEB_CYC_00);
         2'h1:    deb_limit = dcc_pkg::DEB_CNT_W'(DEB_CYC_01);
         2'h2:    deb_limit = dcc_pkg::DEB_CNT_W'(DEB_CYC_10);
         default: deb_limit = dcc_pkg::DEB_CNT_W'(DEB_CYC_11);
      endcase
   end

   // One synchroniser and debounce counter per multipurpose pin.
   genvar g;
   generate
      for (g = 0; g < N_MP; g = g + 1) begin : g_deb
         logic                          s1_reg, s2_reg;
         logic                          lvl_reg, lvl_next;
         logic [dcc_pkg::DEB_CNT_W-1:0] cnt_reg, cnt_next;

         // A level must differ from the output for the whole debounce time to be taken.
         always_comb begin
            lvl_next = lvl_reg;
            cnt_next = '0;
            if (!i_gpio_in_en[g]) begin
               lvl_next = 1'b0;
            end else if (s2_reg != lvl_reg) begin
               if (cnt_reg >= deb_limit - 1'b1) begin
                  lvl_next = s2_reg;
               end else begin
                  cnt_next = cnt_reg + 1'b1;
               end
            end
         end

         // Two-stage synchroniser on the pin, then the debounce state.
         always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               s1_reg  <= 1'b0;
               s2_reg  <= 1'b0;
               lvl_reg <= 1'b0;
               cnt_reg <= '0;
            end else begin
               s1_reg  <= i_mp_pin[g];
               s2_reg  <= s1_reg;
               lvl_reg <= lvl_next;
               cnt_reg <= cnt_next;
            end
         end

         assign o_gpio_level[g] = lvl_reg;
      end
   endgenerate

endmodule

// [rtl/dcc_pkg.sv]
// Shared constants for the signal-processing core control block.
package dcc_pkg;

   // ---------------------------------------------------------------
   // Control port locations, printed as decimal locations 2048..2076.
   // ---------------------------------------------------------------
   localparam int          CP_ADDR_W     = 12;
   localparam int          CP_DATA_W     = 40;
   localparam logic [11:0] LOC_IF_FIRST  = 12'h800;   // 2048
   localparam logic [11:0] LOC_IF_LAST   = 12'h807;   // 2055
   localparam logic [11:0] LOC_AUX_FIRST = 12'h809;   // 2057
   localparam logic [11:0] LOC_AUX_LAST  = 12'h80C;   // 2060
   localparam logic [11:0] LOC_SLD_FIRST = 12'h810;   // 2064
   localparam logic [11:0] LOC_SLD_LAST  = 12'h814;   // 2068
   localparam logic [11:0] LOC_SLA_FIRST = 12'h815;   // 2069
   localparam logic [11:0] LOC_SLA_LAST  = 12'h819;   // 2073
   localparam logic [11:0] LOC_CORE_CTRL = 12'h81C;   // 2076

   // ---------------------------------------------------------------
   // Core control register fields.
   // ---------------------------------------------------------------
   localparam int           BIT_RATE_LO   = 0;
   localparam int           BIT_CORE_RUN  = 2;
   localparam int           BIT_DAC_UNM   = 3;
   localparam int           BIT_ADC_UNM   = 4;
   localparam int           BIT_SL_INIT   = 5;
   localparam int           BIT_IF_HW     = 6;
   localparam int           BIT_GP_HW     = 7;
   localparam int           BIT_AUX_HW    = 8;
   localparam int           BIT_DEB_LO    = 12;
   localparam logic [15:0]  CTRL_RESET    = 16'h0000;
   localparam logic [15:0]  CTRL_WMASK    = 16'h31DF;  // Writable bits, initiate excluded.

   // ---------------------------------------------------------------
   // Instructions per sample.
   // ---------------------------------------------------------------
   localparam logic [10:0] IPS_1X = 11'h400;   // 1024
   localparam logic [10:0] IPS_2X = 11'h200;   // 512
   localparam logic [10:0] IPS_4X = 11'h100;   // 256

   // ---------------------------------------------------------------
   // Debounce times and their cycle counts.
   // ---------------------------------------------------------------
   localparam int CLK_HZ      = 20_000_000;
   localparam int DEB_MS_00   = 20;
   localparam int DEB_MS_01   = 40;
   localparam int DEB_MS_10   = 10;
   localparam int DEB_MS_11   = 5;
   localparam int DEB_CYC_00  = DEB_MS_00 * (CLK_HZ / 1000);
   localparam int DEB_CYC_01  = DEB_MS_01 * (CLK_HZ / 1000);
   localparam int DEB_CYC_10  = DEB_MS_10 * (CLK_HZ / 1000);
   localparam int DEB_CYC_11  = DEB_MS_11 * (CLK_HZ / 1000);
   localparam int DEB_CNT_W   = 20;

   // ---------------------------------------------------------------
   // Safeload.
   // ---------------------------------------------------------------
   localparam int SL_PAIRS  = 5;
   localparam int SL_ADDR_W = 12;
   localparam int SL_DATA_W = 40;
   localparam int SL_IDX_W  = 3;

   typedef enum logic {
      SL_IDLE,
      SL_SCAN
   } dcc_sl_state_e;

endpackage

// [rtl/dcc_safeload.sv]
// Safeload engine: five address and data pairs moved into parameter RAM.
`timescale 1ns/100ps
module dcc_safeload (
   input  wire logic                           i_clk,
   input  wire logic                           i_rst_n,
   dcc_safeload_if.eng                         sl,
   output logic                                o_pram_we,
   output logic [dcc_pkg::SL_ADDR_W-1:0]       o_pram_addr,
   output logic [dcc_pkg::SL_DATA_W-1:0]       o_pram_data
);

   // ---------------------------------------------------------------
   // State.
   // ---------------------------------------------------------------
   dcc_pkg::dcc_sl_state_e                                 state_reg,   state_next;
   logic [dcc_pkg::SL_IDX_W-1:0]                           idx_reg,     idx_next;
   logic [dcc_pkg::SL_PAIRS-1:0]                           dirty_reg,   dirty_next;
   logic [dcc_pkg::SL_PAIRS-1:0][dcc_pkg::SL_ADDR_W-1:0]   addr_reg,    addr_next;
   logic [dcc_pkg::SL_PAIRS-1:0][dcc_pkg::SL_DATA_W-1:0]   data_reg,    data_next;
   logic                                                   we_reg,      we_next;
   logic [dcc_pkg::SL_ADDR_W-1:0]                          oaddr_reg,   oaddr_next;
   logic [dcc_pkg::SL_DATA_W-1:0]                          odata_reg,   odata_next;

   localparam logic [dcc_pkg::SL_IDX_W-1:0] LAST_IDX = dcc_pkg::SL_IDX_W'(dcc_pkg::SL_PAIRS - 1);

   // Scan visits each pair once, one per clock, so a transfer ends five cycles after start;
   // this is far inside one frame period at any supported sample rate.
   always_comb begin
      state_next = state_reg;
      idx_next   = idx_reg;
      dirty_next = dirty_reg;
      addr_next  = addr_reg;
      data_next  = data_reg;
      we_next    = 1'b0;
      oaddr_next = oaddr_reg;
      odata_next = odata_reg;
      sl.done    = 1'b0;
      case (state_reg)
         dcc_pkg::SL_IDLE: begin
            if (sl.start) begin
               state_next = dcc_pkg::SL_SCAN;
               idx_next   = '0;
            end
         end
         dcc_pkg::SL_SCAN: begin
            if (dirty_reg[idx_reg]) begin
               we_next             = 1'b1;
               oaddr_next          = addr_reg[idx_reg];
               odata_next          = data_reg[idx_reg];
               dirty_next[idx_reg] = 1'b0;
            end
            if (idx_reg == LAST_IDX) begin
               state_next = dcc_pkg::SL_IDLE;
               sl.done    = 1'b1;
            end else begin
               idx_next = idx_reg + 1'b1;
            end
         end
         default: begin
            state_next = dcc_pkg::SL_IDLE;
         end
      endcase
      // A host write marks its pair pending; it wins over a clear in the same cycle.
      if (sl.wr && (sl.wr_idx < dcc_pkg::SL_IDX_W'(dcc_pkg::SL_PAIRS))) begin
         dirty_next[sl.wr_idx] = 1'b1;
         if (sl.wr_is_addr) begin
            addr_next[sl.wr_idx] = sl.wr_data[dcc_pkg::SL_ADDR_W-1:0];
         end else begin
            data_next[sl.wr_idx] = sl.wr_data;
         end
      end
   end

   // Register stage.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= dcc_pkg::SL_IDLE;
         idx_reg   <= '0;
         dirty_reg <= '0;
         addr_reg  <= '0;
         data_reg  <= '0;
         we_reg    <= 1'b0;
         oaddr_reg <= '0;
         odata_reg <= '0;
      end else begin
         state_reg <= state_next;
         idx_reg   <= idx_next;
         dirty_reg <= dirty_next;
         addr_reg  <= addr_next;
         data_reg  <= data_next;
         we_reg    <= we_next;
         oaddr_reg <= oaddr_next;
         odata_reg <= odata_next;
      end
   end

   assign sl.busy     = (state_reg == dcc_pkg::SL_SCAN);
   assign o_pram_we   = we_reg;
   assign o_pram_addr = oaddr_reg;
   assign o_pram_data = odata_reg;

endmodule

// [rtl/dcc_safeload_if.sv]
// Link between the control register bank and the safeload engine.
`timescale 1ns/100ps
interface dcc_safeload_if;
   logic                               wr;
   logic                               wr_is_addr;
   logic [dcc_pkg::SL_IDX_W-1:0]       wr_idx;
   logic [dcc_pkg::SL_DATA_W-1:0]      wr_data;
   logic                               start;
   logic                               busy;
   logic                               done;

   modport ctl (output wr, output wr_is_addr, output wr_idx, output wr_data, output start,
                input busy, input done);
   modport eng (input wr, input wr_is_addr, input wr_idx, input wr_data, input start,
                output busy, output done);
endinterface

// [testbench/dcc_core_control_checker.sv]
// Port-level assertions for the core control register block.
`timescale 1ns/100ps
module dcc_core_control_checker (
   input wire logic             i_clk,
   input wire logic             i_rst_n,
   input wire logic             i_cp_wr,
   input wire logic             i_cp_rd,
   input wire logic [11:0]      i_cp_addr,
   input wire logic [39:0]      i_cp_wdata,
   input wire logic [39:0]      o_cp_rdata,
   input wire logic [11:0]      i_mp_pin,
   input wire logic [11:0]      o_gpio_level,
   input wire logic [3:0][11:0] o_aux_adc_data,
   input wire logic [7:0][31:0] o_if_data,
   input wire logic             o_pram_we,
   input wire logic             o_adc_mute,
   input wire logic             o_dac_mute,
   input wire logic             o_core_clear,
   input wire logic [10:0]      o_instr_per_sample
);
   logic       aux_m;
   logic       if_m;
   logic [3:0] cnt;
   logic       ctl_wr;
   logic       ctl_rd;
   assign ctl_wr = i_cp_wr && i_cp_addr == 12'h81C;
   assign ctl_rd = i_cp_rd && i_cp_addr == 12'h81C;
   // Mirror the write modes and count cycles since initiate; saturating, so late reads stay defined.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aux_m <= 1'b0;
         if_m  <= 1'b0;
         cnt   <= 4'hF;
      end else begin
         aux_m <= ctl_wr ? i_cp_wdata[8] : aux_m;
         if_m  <= ctl_wr ? i_cp_wdata[6] : if_m;
         cnt   <= (ctl_wr && i_cp_wdata[5]) ? 4'h0 : (cnt == 4'hF ? cnt : cnt + 4'h1);
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   chk_mute_bits: assert property (ctl_wr |=> {o_adc_mute, o_dac_mute, o_core_clear} == ~$past(i_cp_wdata[4:2]))
      else $error("mute outputs wrong");
   chk_rate_sel: assert property (ctl_wr |=> o_instr_per_sample == ($past(i_cp_wdata[1:0]) == 2'h1 ? 11'h200 :
      $past(i_cp_wdata[1:0]) == 2'h2 ? 11'h100 : 11'h400)) else $error("rate wrong");
   chk_rsvd_zero: assert property (ctl_rd |=> (o_cp_rdata[15:9] & 7'h67) == 7'h0)
      else $error("reserved bits set");
   chk_init_busy: assert property (ctl_rd && cnt == 4'h0 |=> o_cp_rdata[5])
      else $error("initiate not seen");
   chk_init_clear: assert property (ctl_rd && cnt == 4'hF |=> !o_cp_rdata[5])
      else $error("initiate stuck");
   chk_pram_window: assert property (o_pram_we |-> cnt <= 4'h8)
      else $error("transfer too late");
   chk_deb_stable: assert property ($rose(o_gpio_level[0]) |-> $past(i_mp_pin[0], 4) && $past(i_mp_pin[0], 5))
      else $error("level rose early");
   chk_aux_write: assert property (aux_m && i_cp_wr && i_cp_addr == 12'h809 |=> o_aux_adc_data[0] == $past(i_cp_wdata[11:0]))
      else $error("aux write lost");
   chk_aux_hold: assert property (aux_m && !(i_cp_wr && i_cp_addr inside {[12'h809:12'h80C]}) |=> $stable(o_aux_adc_data))
      else $error("aux overwritten");
   chk_if_write: assert property (if_m && i_cp_wr && i_cp_addr == 12'h803 |=> o_if_data[3] == $past(i_cp_wdata[31:0]))
      else $error("if write lost");
   chk_if_block: assert property (if_m && !(i_cp_wr && i_cp_addr[11:3] == 9'h100) |=> $stable(o_if_data))
      else $error("if overwritten");
endmodule
bind dcc_core_control dcc_core_control_checker u_chk (.i_clk, .i_rst_n, .i_cp_wr, .i_cp_rd, .i_cp_addr,
   .i_cp_wdata, .o_cp_rdata, .i_mp_pin, .o_gpio_level, .o_aux_adc_data, .o_if_data, .o_pram_we,
   .o_adc_mute, .o_dac_mute, .o_core_clear, .o_instr_per_sample);

// [testbench/tb_top.sv]
// Self-checking bench for the core control register block.
`timescale 1ns/100ps
module tb_top;
   logic i_clk, i_rst_n, i_cp_wr, i_cp_rd, o_cp_rvalid, i_dsp_if_we, o_pram_we, o_adc_mute, o_dac_mute, o_core_clear;
   logic o_gp_host_write_mode;
   logic [11:0] i_cp_addr, i_mp_pin, i_gpio_in_en, o_gpio_level, o_pram_addr;
   logic [39:0] i_cp_wdata, o_cp_rdata, o_pram_data;
   logic [3:0][11:0] i_aux_adc_data, o_aux_adc_data;
   logic [2:0] i_dsp_if_idx;
   logic [31:0] i_dsp_if_data;
   logic [7:0][31:0] o_if_data;
   logic [10:0] o_instr_per_sample;
   int errors = 0, n_compared = 0, cyc = 0, np;
   // Short debounce counts keep the run brief.
   dcc_core_control #(.DEB_CYC_00(20), .DEB_CYC_01(40), .DEB_CYC_10(10), .DEB_CYC_11(5)) dut (
      .i_clk, .i_rst_n, .i_cp_wr, .i_cp_rd, .i_cp_addr, .i_cp_wdata, .o_cp_rdata, .o_cp_rvalid,
      .i_mp_pin, .i_gpio_in_en, .o_gpio_level, .i_aux_adc_data, .o_aux_adc_data, .i_dsp_if_we,
      .i_dsp_if_idx, .i_dsp_if_data, .o_if_data, .o_pram_we, .o_pram_addr, .o_pram_data,
      .o_adc_mute, .o_dac_mute, .o_core_clear, .o_instr_per_sample, .o_gp_host_write_mode);
   // Free-running 50 ns clock.
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   // Cut a hang short; the tests need about 130 cycles.
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [63:0] s, input logic [63:0] e);
      n_compared++;
      if (s !== e) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // One port access; strobes stay up so back-to-back accesses never toggle twice in a step.
   task automatic acc(input logic w, input logic [11:0] a, input logic [39:0] d);
      i_cp_wr = w;
      i_cp_rd = !w;
      i_cp_addr = a;
      i_cp_wdata = d;
      @(posedge i_clk);
      #1;
   endtask
   task automatic rd(input logic [11:0] a, input logic [39:0] e);
      acc(1'b0, a, 40'h0);
      chk(64'({o_cp_rvalid, o_cp_rdata}), 64'({1'b1, e}));
   endtask
   task automatic idle(input int n);
      i_cp_wr = 1'b0;
      i_cp_rd = 1'b0;
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic t_ctrl();
      for (int k = 0; k < 4; k++) begin
         acc(1'b1, 12'h81C, 40'h9C | 40'(k));
         rd(12'h81C, 40'h9C | 40'(k));
         chk(o_instr_per_sample, k == 1 ? 11'h200 : k == 2 ? 11'h100 : 11'h400);
         chk({o_adc_mute, o_dac_mute, o_core_clear, o_gp_host_write_mode}, 4'h1);
      end
      $display("control test done");
   endtask
   task automatic t_safe();
      acc(1'b1, 12'h816, 40'h123);
      acc(1'b1, 12'h811, 40'hAB_CDEF_0123);
      acc(1'b1, 12'h813, 40'h55);
      acc(1'b1, 12'h81C, 40'h3C);
      rd(12'h81C, 40'h3C);
      for (int r = 0; r < 2; r++) begin
         np = 0;
         repeat (16) begin
            idle(1);
            if (o_pram_we === 1'b1) begin
               chk(o_pram_addr, np == 0 ? 12'h123 : 12'h0);
               chk(o_pram_data, np == 0 ? 40'hAB_CDEF_0123 : 40'h55);
               np++;
            end
         end
         chk(64'(np), r == 0 ? 64'h2 : 64'h0);
         rd(12'h81C, 40'h1C);
         acc(1'b1, 12'h81C, 40'h3C);
      end
      $display("safeload test done");
   endtask
   task automatic t_modes();
      i_aux_adc_data = {12'h444, 12'h333, 12'h222, 12'h111};
      acc(1'b1, 12'h81C, 40'h11C);
      acc(1'b1, 12'h809, 40'hABC);
      i_aux_adc_data = {4{12'h777}};
      idle(3);
      chk(o_aux_adc_data, {12'h444, 12'h333, 12'h222, 12'hABC});
      i_dsp_if_idx = 3'h3;
      i_dsp_if_data = 32'h1111_2222;
      i_dsp_if_we = 1'b1;
      acc(1'b1, 12'h81C, 40'h5C);
      i_dsp_if_we = 1'b0;
      chk(o_if_data[3], 32'h1111_2222);
      acc(1'b1, 12'h803, 40'h9999_8888);
      chk(o_aux_adc_data, {4{12'h777}});
      i_dsp_if_we = 1'b1;
      idle(2);
      chk(o_if_data[3], 32'h9999_8888);
      i_dsp_if_we = 1'b0;
      $display("mode test done");
   endtask
   task automatic t_gpio();
      i_gpio_in_en = 12'h001;
      i_mp_pin = 12'h003;
      acc(1'b1, 12'h81C, 40'h301C);
      idle(3);
      chk(o_gpio_level, 12'h0);
      idle(12);
      chk(o_gpio_level, 12'h001);
      i_mp_pin = 12'h0;
      acc(1'b1, 12'h81C, 40'h101C);
      idle(25);
      chk(o_gpio_level, 12'h001);
      idle(25);
      chk(o_gpio_level, 12'h0);
      $display("debounce test done");
   endtask
   // Reset for six cycles, then run every test.
   initial begin
      {i_rst_n, i_cp_wr, i_cp_rd, i_cp_addr, i_cp_wdata, i_mp_pin, i_gpio_in_en} = '0;
      {i_aux_adc_data, i_dsp_if_we, i_dsp_if_idx, i_dsp_if_data} = '0;
      repeat (6) @(posedge i_clk);
      #1;
      i_rst_n = 1'b1;
      rd(12'h81C, 40'h0);
      chk({o_adc_mute, o_dac_mute, o_core_clear, o_gp_host_write_mode, o_instr_per_sample}, {3'h7, 1'b0, 11'h400});
      t_ctrl();
      t_safe();
      t_modes();
      t_gpio();
      report_and_stop();
   end
endmodule
